/* hw/hwcr_pkg.sv */
/*
  Constants for the halt wake and clock restart block: register map,
  reset values, power-down mode codes, state codes and timing counts.
  Assumes a single 20 MHz system clock.
*/
`default_nettype none

package hwcr_pkg;

  // System clock period in ns
  localparam int CLK_PERIOD_NS = 50;
  // Warm-up time in half clock periods: 2*(2**14 + 2.5)
  localparam int WARM_HALF_PER = 32773;
  // Least time, so the cycle count rounds up
  localparam int WARM_CYC = (WARM_HALF_PER * CLK_PERIOD_NS
    + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int WARM_W = 15;
  localparam int RST_STRETCH_CYC = 16;
  localparam int RST_MIN_CYC = 3;
  localparam int DUMMY_T = 2;

  // Byte offsets on the register bus
  localparam logic [7:0] A_MCR = 8'h00;
  localparam logic [7:0] A_WDM = 8'h04;
  localparam logic [7:0] A_WDC = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [3:0] A_GEN_HI = 4'h1;

  // Reset values
  localparam logic [7:0] MCR_RST = 8'h01;
  localparam logic [7:0] WDM_RST = 8'h18;
  // refresh_ctrl, wait_ctrl, mem_bound, cs_bound
  localparam logic [3:0][7:0] GEN_RST = {8'hFF, 8'h00, 8'h00, 8'h00};

  // Field positions and keys
  localparam int F_ROD = 3;
  localparam int F_PDS = 3;
  localparam logic [7:0] WDC_KEY = 8'hDB;

  // power_down_select codes
  localparam logic [1:0] PDS_IDLE_OSC = 2'b00;
  localparam logic [1:0] PDS_IDLE_TMR = 2'b01;
  localparam logic [1:0] PDS_STOP = 2'b10;
  localparam logic [1:0] PDS_RUN = 2'b11;

  // Fetch vectors
  localparam logic [15:0] ADDR_VEC_RST = 16'h0000;
  localparam logic [15:0] ADDR_VEC_NMI = 16'h0066;

  typedef enum logic [8:0] {
    ST_RUN     = 9'h001,
    ST_HALTRUN = 9'h002,
    ST_SLEEP   = 9'h004,
    ST_DEEP    = 9'h008,
    ST_WARM    = 9'h010,
    ST_WAKE    = 9'h020,
    ST_REGATE  = 9'h040,
    ST_RESET   = 9'h080,
    ST_DUMMY   = 9'h100
  } hwcr_state_t;

endpackage

`default_nettype wire

/* hw/hwcr_warm_if.sv */
/*
  Carrier between the sequencer and its oscillator warm-up counter.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface hwcr_warm_if;
  logic start;
  logic clr;
  logic done;
  modport ctl (output start, output clr, input done);
  modport cnt (input start, input clr, output done);
endinterface

`default_nettype wire

/* hw/hwcr_warm_cnt.sv */
/*
  Oscillator warm-up counter: counts TERM clocks from zero after start
  and then pulses done for one cycle.
  Assumes start and clr come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module hwcr_warm_cnt #(
  parameter int W = 15,
  parameter logic [W-1:0] TERM = '1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  hwcr_warm_if.cnt wi
);

  logic [W-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  wire last = busy_q && (cnt_q == TERM - 1'b1);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (wi.clr) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // Restart from zero on every start
      cnt_q <= wi.start ? '0 : cnt_q + 1'b1; // R20
      busy_q <= wi.start || (busy_q && !last);
      done_q <= last && !wi.start; // R20
    end
  end

  assign wi.done = done_q;

endmodule // hwcr_warm_cnt

`default_nettype wire

/* hw/hwcr_top.sv */
/*
  Halt wake and clock restart sequencer with reset stretcher and its
  control registers on an AHB-Lite slave port.
  Assumes the core gives one-cycle strobes for the sleep fetch, the rise
  of T4 and the low phase of T4, all on clk_sys; pins are asynchronous.
*/
// Overview of operation
// R1 - Any wake source restarts a gated system clock immediately; code waits for warm-up on an interrupt in mode 10.
// R2 - Run mode keeps clock; interrupt at idle T4 rise is taken next cycle.
// R3 - Outside holds reset low at least 3 cycles from a halted state.
// R4 - After reset release, two dummy T states, then fetch from 0000H.
// R5 - Light modes: interrupt restarts clock; mode 00 restarts output too.
// R6 - After restart run one idle instruction, sample interrupts at its T4.
// R7 - No interrupt taken: gate clock again at that T4 low phase.
// R8 - Outside holds maskable interrupt low at the wake idle T4 rise.
// R9 - Reset in light sleep restarts clock; execution starts at 0000H.
// R10 - Mode 10: interrupt restarts oscillator, clocks wait for warm-up.
// R11 - Reset in deep sleep restarts oscillator without warm-up count.
// R12 - Reset pulse stretched to 16 cycles and driven out unless disabled.
// R13 - Reset returns all control registers to defaults.
// R14 - Outside holds reset 2 cycles if output enabled, else 3.
// R15 - During reset buses float, controls inactive, program counter cleared.
// R16 - Nonmaskable interrupt sampled alike, has priority, vector 0066H.
// R17 - Mode field changes only after key DBh written to command register.
// R18 - Sleep fetch drives sleep indicator low at T4 falling edge.
// R19 - Timer-clock mode keeps oscillator, timer and clock output running.
// R20 - Warm-up counts from zero per wake, releases clocks at terminal.
`timescale 1ns/1ps
`default_nettype none

module hwcr_top
  import hwcr_pkg::*;
#(
  parameter int WARM_CYCLES = hwcr_pkg::WARM_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_oe,
  input wire logic nmi_n,
  input wire logic maskable_irq_n,
  // Core sequencer
  input wire logic sleep_fetch,
  input wire logic t4_rise,
  input wire logic t4_low,
  output logic core_reset,
  output logic fetch_start,
  output logic [15:0] fetch_addr,
  output logic nmi_take,
  output logic int_take,
  // Clock gates
  output logic osc_en,
  output logic sys_clk_en,
  output logic clk_out_en,
  output logic timer_clk_en,
  output logic sleep_indicator_n
);

  import hwcr_pkg::*;

  hwcr_state_t st_q, st_d;
  logic [2:0] s1_q, s2_q;
  logic rst_lo_q, oe_q, armed_q;
  logic [4:0] rcnt_q, oe_run_q;
  logic dph_q, dwr_q;
  logic [7:0] dadr_q, mcr_q, wdm_q;
  logic [3:0][7:0] gen_q;
  logic [31:0] hrdata_q, rd_d;
  logic dcnt_q, dcnt_d;
  logic osc_q, sys_q, cko_q, tmr_q, sin_q, sin_d;
  logic crst_q, fst_q, fst_d, ntk_q, ntk_d, itk_q, itk_d;
  logic [15:0] fad_q, fad_d;
  logic warm_go;

  hwcr_warm_if wi ();
  hwcr_warm_cnt #(
    .W(WARM_W),
    .TERM(WARM_W'(WARM_CYCLES))
  ) u_warm (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wi(wi)
  );

  // Pin synchronisers: reset, nmi, maskable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
    end else begin
      s1_q <= {reset_pin_n_in, nmi_n, maskable_irq_n};
      s2_q <= s1_q;
    end
  end

  wire rst_lo = !s2_q[2];
  wire nmi_req = !s2_q[1];
  wire int_req = !s2_q[0]; // R8
  wire irq = nmi_req || int_req;
  // Our own drive returns through the synchroniser two cycles late and
  // would look like a fresh fall; a stretch in progress is never restarted
  wire rst_fall = rst_lo && !rst_lo_q && !oe_q; // R12
  // Our own drive keeps the pin low, so the stretch holds the core too
  wire hold_rst = rst_lo || oe_q; // R14
  wire [1:0] pds = wdm_q[F_PDS+1:F_PDS];

  // Bus decode
  wire ahb_go = hsel && htrans[1] && hready;
  wire wr = dph_q && dwr_q;
  wire wr_mcr = wr && (dadr_q == A_MCR);
  wire wr_wdm = wr && (dadr_q == A_WDM);
  wire wr_wdc = wr && (dadr_q == A_WDC);
  wire wr_gen = wr && (dadr_q[7:4] == A_GEN_HI);
  wire [1:0] gidx = dadr_q[3:2];
  wire [3:0] stat_clk = {tmr_q, osc_q, sys_q, cko_q};

  always_comb begin
    rd_d = 32'h0000_0000;
    if (haddr[7:0] == A_MCR) begin
      rd_d = {24'h00_0000, mcr_q};
    end else if (haddr[7:0] == A_WDM) begin
      rd_d = {24'h00_0000, wdm_q};
    end else if (haddr[7:0] == A_STAT) begin
      rd_d = {17'h0_0000, armed_q, sin_q, stat_clk, st_q};
    end else if (haddr[7:4] == A_GEN_HI) begin
      rd_d = {24'h00_0000, gen_q[haddr[3:2]]};
    end
  end

  // Zero wait state: answer always ready and OKAY
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      dadr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      dph_q <= ahb_go;
      dwr_q <= ahb_go && hwrite;
      if (ahb_go) begin
        dadr_q <= haddr[7:0];
      end
      if (ahb_go && !hwrite) begin
        hrdata_q <= rd_d;
      end
    end
  end

  // Control registers; the reset pin restores defaults as well
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mcr_q <= MCR_RST;
      wdm_q <= WDM_RST;
      gen_q <= GEN_RST;
      armed_q <= 1'b0;
    end else if (rst_lo) begin
      mcr_q <= MCR_RST; // R13
      wdm_q <= WDM_RST; // R13
      gen_q <= GEN_RST; // R13
      armed_q <= 1'b0;
    end else begin
      if (wr_mcr) begin
        mcr_q <= {3'b000, hwdata[4:0]};
      end
      if (wr_wdm) begin
        wdm_q <= armed_q ? hwdata[7:0] : // R17
          {hwdata[7:5], wdm_q[4:3], hwdata[2:0]};
      end
      if (wr_gen) begin
        gen_q[gidx] <= hwdata[7:0];
      end
      if (wr_wdc || wr_wdm) begin
        armed_q <= wr_wdc && (hwdata[7:0] == WDC_KEY); // R17
      end
    end
  end

  // Reset stretcher, driven low on the open-drain pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_lo_q <= 1'b0;
      oe_q <= 1'b0;
      rcnt_q <= 5'h00;
    end else begin
      rst_lo_q <= rst_lo;
      if (rst_fall && !mcr_q[F_ROD]) begin
        oe_q <= 1'b1; // R12
        rcnt_q <= 5'h00;
      end else if (oe_q) begin
        rcnt_q <= rcnt_q + 5'h01;
        oe_q <= (rcnt_q != 5'(RST_STRETCH_CYC - 1)); // R12
      end
    end
  end

  // Sequencer
  always_comb begin
    st_d = st_q;
    sin_d = sin_q;
    fst_d = 1'b0;
    ntk_d = 1'b0;
    itk_d = 1'b0;
    fad_d = fad_q;
    dcnt_d = dcnt_q;
    warm_go = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (sleep_fetch) begin
          sin_d = 1'b0; // R18
          if (pds == PDS_RUN) begin
            st_d = ST_HALTRUN; // R2
          end else if (pds == PDS_STOP) begin
            st_d = ST_DEEP;
          end else begin
            st_d = ST_SLEEP; // R19
          end
        end
      end
      ST_HALTRUN, ST_WAKE: begin
        if (t4_rise && irq) begin
          ntk_d = nmi_req; // R16
          itk_d = !nmi_req; // R6
          if (nmi_req) begin
            fad_d = ADDR_VEC_NMI; // R16
          end
          sin_d = 1'b1;
          st_d = ST_RUN;
        end else if (t4_rise && st_q == ST_WAKE) begin
          st_d = ST_REGATE; // R7
        end
      end
      ST_REGATE: begin
        if (t4_low) begin
          st_d = (pds == PDS_STOP) ? ST_DEEP : ST_SLEEP; // R7
        end
      end
      ST_SLEEP: begin
        if (irq) begin
          st_d = ST_WAKE; // R1
        end
      end
      ST_DEEP: begin
        if (irq) begin
          warm_go = 1'b1; // R10
          st_d = ST_WARM;
        end
      end
      ST_WARM: begin
        if (wi.done) begin
          st_d = ST_WAKE; // R20
        end
      end
      ST_RESET: begin
        dcnt_d = 1'b0;
        st_d = ST_DUMMY;
      end
      ST_DUMMY: begin
        dcnt_d = 1'b1;
        if (dcnt_q == 1'(DUMMY_T - 1)) begin
          fst_d = 1'b1; // R4
          fad_d = ADDR_VEC_RST; // R4
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RUN;
    endcase
    if (hold_rst) begin
      // Reset restarts oscillator and clocks at once, no warm-up
      st_d = ST_RESET; // R9 R11
      sin_d = 1'b1;
      fst_d = 1'b0;
      ntk_d = 1'b0;
      itk_d = 1'b0;
    end
  end

  wire gated_d = (st_d == ST_SLEEP) || (st_d == ST_DEEP) ||
    (st_d == ST_WARM);
  wire keep_tmr = (st_d == ST_SLEEP) && (pds == PDS_IDLE_TMR);
  assign wi.start = warm_go;
  assign wi.clr = hold_rst;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RUN;
      sin_q <= 1'b1;
      osc_q <= 1'b1;
      sys_q <= 1'b1;
      cko_q <= 1'b1;
      tmr_q <= 1'b1;
      crst_q <= 1'b0;
      fst_q <= 1'b0;
      fad_q <= ADDR_VEC_RST;
      ntk_q <= 1'b0;
      itk_q <= 1'b0;
      dcnt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sin_q <= sin_d;
      osc_q <= (st_d != ST_DEEP); // R10 R11
      sys_q <= !gated_d; // R1 R5
      cko_q <= !gated_d || keep_tmr; // R5 R19
      tmr_q <= !gated_d || keep_tmr; // R19
      crst_q <= (st_d == ST_RESET); // R15
      fst_q <= fst_d;
      fad_q <= (st_d == ST_RESET) ? ADDR_VEC_RST : fad_d; // R15
      ntk_q <= ntk_d;
      itk_q <= itk_d;
      dcnt_q <= dcnt_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_oe = oe_q;
  assign core_reset = crst_q;
  assign fetch_start = fst_q;
  assign fetch_addr = fad_q;
  assign nmi_take = ntk_q;
  assign int_take = itk_q;
  assign osc_en = osc_q;
  assign sys_clk_en = sys_q;
  assign clk_out_en = cko_q;
  assign timer_clk_en = tmr_q;
  assign sleep_indicator_n = sin_q;

  // Checks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oe_run_q <= 5'h00;
    end else begin
      oe_run_q <= oe_q ? oe_run_q + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence dummy_seq;
    (!fst_q)[*2] ##1 (fst_q && fad_q == ADDR_VEC_RST);
  endsequence

  wake_clock_a: // R1
  assert property (st_q == ST_SLEEP && irq && !hold_rst |=> sys_q)
    else $error("clock not restarted on wake");
  run_take_a: // R2
  assert property (st_q == ST_HALTRUN && t4_rise && irq && !hold_rst
    |=> (ntk_q || itk_q) && sin_q)
    else $error("run mode interrupt not taken");
  dummy_fetch_a: // R4
  assert property ($fell(crst_q) && !hold_rst |-> dummy_seq)
    else $error("dummy period or reset fetch wrong");
  system_clock_output_same_a: // R5
  assert property (st_q == ST_SLEEP && pds == PDS_IDLE_OSC && irq &&
    !hold_rst |=> cko_q && sys_q && $past(!cko_q))
    else $error("clock output not resumed with clock");
  regate_a: // R7
  assert property (st_q == ST_REGATE && t4_low && !hold_rst
    |=> !sys_q && !sin_q)
    else $error("clock not gated after idle");
  warm_hold_a: // R10
  assert property (st_q == ST_WARM && !wi.done && !hold_rst
    |=> !sys_q && !cko_q && osc_q)
    else $error("clocks released before warm-up end");
  reset_restart_a: // R11
  assert property (hold_rst |=> osc_q && sys_q && crst_q)
    else $error("reset did not restart clocks");
  stretch_len_a: // R12
  assert property ($fell(oe_q) |-> oe_run_q == 5'(RST_STRETCH_CYC))
    else $error("reset stretch length wrong");
  reg_default_a: // R13
  assert property (rst_lo |=> mcr_q == MCR_RST && wdm_q == WDM_RST)
    else $error("registers not restored by reset");
  nmi_prio_a: // R16
  assert property (ntk_q |-> !itk_q && fad_q == ADDR_VEC_NMI)
    else $error("nonmaskable priority or vector wrong");
  mode_lock_a: // R17
  assert property (wr_wdm && !armed_q && !rst_lo |=> $stable(pds))
    else $error("mode changed without key");
  sleep_ind_a: // R18
  assert property (st_q == ST_RUN && sleep_fetch && !hold_rst |=> !sin_q)
    else $error("sleep indicator not driven");

endmodule // hwcr_top

`default_nettype wire

/* tb/hwcr_core_model.sv */
/*
  Behavioural model of the core sequencer beside the halt wake block:
  issues the sleep fetch strobe on request and runs idle instructions
  with T4 strobes while halted and clocked.
  Assumes the bench pulses halt_req for one cycle while running.
*/
`timescale 1ns/1ps
`default_nettype none

module hwcr_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bench command
  input wire logic halt_req,
  // Design side
  input wire logic sys_clk_en,
  input wire logic sleep_indicator_n,
  input wire logic core_reset,
  output logic sleep_fetch,
  output logic t4_rise,
  output logic t4_low
);
  logic [2:0] ph_q;
  logic idling;

  // Idle instructions only run while halted with the clock fed
  assign idling = sys_clk_en && !sleep_indicator_n && !core_reset;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 3'h0;
      sleep_fetch <= 1'b0;
      t4_rise <= 1'b0;
      t4_low <= 1'b0;
    end else begin
      sleep_fetch <= halt_req;
      // Six-cycle idle loop: T4 rise at phase 4, T4 low at phase 5
      ph_q <= (!idling || ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
      t4_rise <= idling && ph_q == 3'h4;
      t4_low <= idling && ph_q == 3'h5;
    end
  end
endmodule // hwcr_core_model

`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench for the halt wake and clock restart block.
  Assumes hwcr_pkg and the core model are compiled first; the warm-up
  count is shortened to 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import hwcr_pkg::*;

  localparam int WARM = 8;
  localparam int LIMIT = 20000;

  logic clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ext_rst_n, reset_pin_n_out, reset_pin_oe, nmi_n, maskable_irq_n;
  logic reset_pin_n_in, halt_req, sleep_fetch, t4_rise, t4_low;
  logic core_reset, fetch_start, nmi_take, int_take;
  logic osc_en, sys_clk_en, clk_out_en, timer_clk_en, sleep_indicator_n;
  logic [15:0] fetch_addr;
  int bad_count, total_checks, n_int, n_nmi, cyc, w_cnt;

  assign hready = hreadyout;
  // Open-drain reset pin: the design pulls it low when enabled
  assign reset_pin_n_in = ext_rst_n &
    (reset_pin_oe ? reset_pin_n_out : 1'b1);

  hwcr_top #(.WARM_CYCLES(WARM)) u_hwcr_top (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .reset_pin_n_in(reset_pin_n_in),
    .reset_pin_n_out(reset_pin_n_out), .reset_pin_oe(reset_pin_oe),
    .nmi_n(nmi_n), .maskable_irq_n(maskable_irq_n),
    .sleep_fetch(sleep_fetch), .t4_rise(t4_rise), .t4_low(t4_low),
    .core_reset(core_reset), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr), .nmi_take(nmi_take), .int_take(int_take),
    .osc_en(osc_en), .sys_clk_en(sys_clk_en), .clk_out_en(clk_out_en),
    .timer_clk_en(timer_clk_en), .sleep_indicator_n(sleep_indicator_n));

  hwcr_core_model u_hwcr_core_model (
    .clk_sys(clk_sys), .rstn(rstn), .halt_req(halt_req),
    .sys_clk_en(sys_clk_en), .sleep_indicator_n(sleep_indicator_n),
    .core_reset(core_reset), .sleep_fetch(sleep_fetch),
    .t4_rise(t4_rise), .t4_low(t4_low));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    n_int <= n_int + (int_take === 1'b1);
    n_nmi <= n_nmi + (nmi_take === 1'b1);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // One single AHB-Lite word transfer; hready is sampled at each edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h0);
    chk_word(q, {24'h0, exp});
    chk_bit(hresp, 1'b0);
  endtask

  task automatic set_mode(input logic [1:0] m);
    xfer(1'b1, A_WDC, {24'h0, WDC_KEY});
    xfer(1'b1, A_WDM, {27'h0, m, 3'h0});
  endtask

  task automatic do_halt();
    @(posedge clk_sys);
    halt_req <= 1'b1;
    @(posedge clk_sys);
    halt_req <= 1'b0;
  endtask

  task automatic wait_en(input logic v);
    for (int k = 0; k < 40 && sys_clk_en !== v; k++) @(posedge clk_sys);
  endtask

  task automatic wait_take();
    for (int k = 0; k < 40 && (int_take | nmi_take) !== 1'b1; k++)
      @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask

  // Pulls the pin low for len cycles and follows the restart to the fetch
  task automatic pin_reset(input int len, input int exp_oe);
    int oe_n, gap;
    logic seen;
    oe_n = 0;
    gap = 0;
    seen = 1'b0;
    @(posedge clk_sys);
    ext_rst_n <= 1'b0;
    for (int k = 0; k < 200 && fetch_start !== 1'b1; k++) begin
      @(posedge clk_sys);
      if (k == len - 1)
        ext_rst_n <= 1'b1;
      oe_n += (reset_pin_oe === 1'b1);
      if (core_reset === 1'b1)
        seen = 1'b1;
      if (seen && core_reset === 1'b0 && fetch_start !== 1'b1)
        gap++;
    end
    chk_word(oe_n, exp_oe);
    chk_bit(seen, 1'b1);
    chk_bit(gap >= DUMMY_T, 1'b1);
    chk_word({16'h0, fetch_addr}, {16'h0, ADDR_VEC_RST});
    chk_bit(sys_clk_en, 1'b1);
    rd_chk(A_MCR, MCR_RST);
    rd_chk(A_WDM, WDM_RST);
    rd_chk(8'h10, GEN_RST[0]);
  endtask

  initial begin
    {hsel, hwrite, halt_req} = '0;
    {bad_count, total_checks} = '0;
    {haddr, hwdata} = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    {ext_rst_n, nmi_n, maskable_irq_n} = 3'b111;
    rstn = 1'b0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;

    rd_chk(A_MCR, MCR_RST);
    rd_chk(A_WDM, WDM_RST);
    rd_chk(A_WDC, 8'h00);
    rd_chk(8'h20, 8'h00);
    for (int i = 0; i < 4; i++)
      rd_chk(8'h10 + 8'(4 * i), GEN_RST[i]);
    $display("test registers done");

    xfer(1'b1, A_WDM, 32'h0);
    rd_chk(A_WDM, WDM_RST);
    set_mode(PDS_RUN);
    rd_chk(A_WDM, {3'h0, PDS_RUN, 3'h0});
    $display("test mode key done");

    do_halt();
    repeat (8) @(posedge clk_sys);
    chk_bit(sleep_indicator_n, 1'b0);
    chk_bit(sys_clk_en, 1'b1);
    maskable_irq_n <= 1'b0;
    wait_take();
    maskable_irq_n <= 1'b1;
    chk_word(n_int, 1);
    chk_bit(sleep_indicator_n, 1'b1);
    $display("test run halt done");

    for (int m = 0; m < 2; m++) begin
      set_mode(2'(m));
      do_halt();
      wait_en(1'b0);
      chk_bit(sys_clk_en, 1'b0);
      chk_bit(osc_en, 1'b1);
      chk_bit(clk_out_en, 2'(m) == PDS_IDLE_TMR);
      chk_bit(timer_clk_en, 2'(m) == PDS_IDLE_TMR);
      maskable_irq_n <= 1'b0;
      @(posedge clk_sys);
      maskable_irq_n <= 1'b1;
      wait_en(1'b1);
      chk_bit(sys_clk_en, 1'b1);
      chk_bit(clk_out_en, 1'b1);
      wait_en(1'b0);
      chk_bit(sys_clk_en, 1'b0);
      chk_word(n_int, 1 + m);
      maskable_irq_n <= 1'b0;
      wait_take();
      maskable_irq_n <= 1'b1;
      chk_word(n_int, 2 + m);
    end
    $display("test light sleep done");

    set_mode(PDS_STOP);
    do_halt();
    for (int k = 0; k < 40 && osc_en !== 1'b0; k++) @(posedge clk_sys);
    chk_bit(sys_clk_en, 1'b0);
    nmi_n <= 1'b0;
    maskable_irq_n <= 1'b0;
    for (int k = 0; k < 10 && osc_en !== 1'b1; k++) @(posedge clk_sys);
    for (w_cnt = 0; w_cnt < 100 && sys_clk_en !== 1'b1; w_cnt++)
      @(posedge clk_sys);
    chk_bit(w_cnt >= WARM && w_cnt <= WARM + 3, 1'b1);
    wait_take();
    {nmi_n, maskable_irq_n} <= 2'b11;
    chk_word(n_nmi, 1);
    chk_word(n_int, 3);
    chk_word({16'h0, fetch_addr}, {16'h0, ADDR_VEC_NMI});
    $display("test deep sleep done");

    set_mode(PDS_IDLE_OSC);
    xfer(1'b1, A_MCR, 32'h0);
    xfer(1'b1, 8'h10, 32'h5A);
    do_halt();
    wait_en(1'b0);
    pin_reset(2, RST_STRETCH_CYC);
    xfer(1'b1, A_MCR, 32'h1 << F_ROD);
    pin_reset(RST_MIN_CYC, 0);
    $display("test pin reset done");
    wrap_up();
  end
endmodule // tb

`default_nettype wire
